// *** common/rps_pkg.sv ***
// Constants and carrier types of the remappable pin select block
`default_nettype none
package rps_pkg;
	// Register byte offsets
	localparam logic [7:0] OSC_CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] IN_BASE_OFS = 8'h40;
	localparam logic [7:0] OUT_BASE_OFS = 8'h80;
	// Input register indices and implemented bits
	localparam int IN_REGS = 5;
	localparam logic [4:0][3:0] IN_INDEX = {4'h7, 4'h4, 4'h3, 4'h1, 4'h0};
	localparam logic [4:0][15:0] IN_MASK = {16'h1F1F, 16'h1F1F, 16'h1F1F, 16'h001F, 16'h1F00};
	localparam logic [15:0] IN_RESET = 16'h1F1F;
	localparam logic [15:0] OUT_MASK = 16'h1F1F;
	localparam logic [15:0] OUT_RESET = 16'h0000;
	// Field positions
	localparam int LO_FIELD = 0;
	localparam int HI_FIELD = 8;
	localparam int LOCK_BIT = 6;
	// Unlock keys
	localparam logic [7:0] KEY_FIRST = 8'h46;
	localparam logic [7:0] KEY_SECOND = 8'h57;
	localparam logic LOCK_RESET = 1'b0;
	localparam logic SINGLE_SESSION_DEFAULT = 1'b1;
	// Output selector codes
	localparam logic [4:0] SEL_NULL = 5'h00;
	localparam logic [4:0] SEL_CMP1 = 5'h01;
	localparam logic [4:0] SEL_CMP2 = 5'h02;
	localparam logic [4:0] SEL_UART1_TRANSMIT = 5'h03;
	localparam logic [4:0] SEL_UART1_REQUEST_TO_SEND = 5'h04;
	localparam logic [4:0] SEL_UART2_TRANSMIT = 5'h05;
	localparam logic [4:0] SEL_UART2_REQUEST_TO_SEND = 5'h06;
	localparam logic [4:0] SEL_SPI1_DO = 5'h07;
	localparam logic [4:0] SEL_SPI1_CK = 5'h08;
	localparam logic [4:0] SEL_SPI1_SS = 5'h09;
	localparam logic [4:0] SEL_SPI2_DO = 5'h0A;
	localparam logic [4:0] SEL_SPI2_CK = 5'h0B;
	localparam logic [4:0] SEL_SPI2_SS = 5'h0C;
	localparam logic [4:0] SEL_CAN_TX = 5'h10;
	localparam logic [4:0] SEL_CMP_OUT1 = 5'h12;
	localparam logic [4:0] SEL_CMP_OUT2 = 5'h13;
	localparam logic [4:0] SEL_CMP_OUT3 = 5'h14;
	localparam logic [4:0] SEL_CMP_OUT4 = 5'h15;
	localparam logic [4:0] SEL_QUAD1 = 5'h1A;
	localparam logic [4:0] SEL_QUAD2 = 5'h1B;
	// Input selector codes
	localparam logic [4:0] SEL_PIN_MAX = 5'h19;
	localparam logic [4:0] SEL_GROUND = 5'h1F;
	// AHB encodings
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;

	typedef struct packed {
		logic comparator1_output;
		logic comparator2_output;
		logic uart1_transmit;
		logic uart1_request_to_send;
		logic uart2_transmit;
		logic uart2_request_to_send;
		logic spi1_data_out;
		logic spi1_clock_out;
		logic spi1_select_out;
		logic spi2_data_out;
		logic spi2_clock_out;
		logic spi2_select_out;
		logic can_transmit;
		logic compare1_output;
		logic compare2_output;
		logic compare3_output;
		logic compare4_output;
		logic quad1_direction;
		logic quad2_direction;
	} rps_periph_out_t;

	typedef struct packed {
		logic ext_irq1;
		logic ext_irq2;
		logic tmr2_clk;
		logic tmr3_clk;
		logic tmr4_clk;
		logic tmr5_clk;
		logic capture1;
		logic capture2;
	} rps_periph_in_t;

	typedef struct packed {
		logic [7:0] addr;
		logic write;
		logic [2:0] size;
	} rps_addr_phase_t;

	typedef enum logic [2:0] {
		KEY_IDLE = 3'b001,
		KEY_HALF = 3'b010,
		KEY_OPEN = 3'b100
	} rps_key_state_t;
endpackage
`default_nettype wire

// *** rtl/rps_pin_select.sv ***
// Remappable pin select: selector registers, write lock, shadow check, pin routing
// Contract
// - Each pin has a 5-bit output selector
// - Code zero leaves pin on port control
// - Codes 1-6 route comparators and UARTs
// - Codes 7-12 route SPI1 and SPI2 outputs
// - Code 16 CAN, 18-21 compare channels
// - Codes 26, 27 route quadrature directions
// - Locked selector writes complete, change nothing
// - Lock is control register bit 6
// - Lock change needs 0x46, 0x57 first
// - Lock holds until deliberately changed
// - Shadow mismatch raises configuration reset request
// - Single-session mode refuses clearing set lock
// - Single-session mode is the default
// - Block has 20 input, 13 output registers (only 5 input registers implemented here)
// - Input code n picks pin, 31 ground
// - Input bits reset one, unimplemented read zero
// - External interrupt selector fields placed
// - Timer clock selector fields placed
// - Capture selector fields placed
//
// Our own choices: the AHB-Lite register port and the register addresses.
`default_nettype none
module rps_pin_select #(
	parameter int NUM_PINS = 26,
	parameter int OUT_REGS = 13
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [1:0] hresp,
	output logic [31:0] hrdata,
	input wire logic single_session_lock_cfg,
	input wire rps_pkg::rps_periph_out_t periph_out,
	input wire logic [NUM_PINS-1:0] port_out,
	input wire logic [NUM_PINS-1:0] port_oe,
	input wire logic [NUM_PINS-1:0] pin_in,
	output logic [NUM_PINS-1:0] pin_out,
	output logic [NUM_PINS-1:0] pin_oe,
	output rps_pkg::rps_periph_in_t periph_in,
	output logic map_mismatch_reset
);

	// Output code to peripheral signal; bit 1 says a peripheral is chosen
	function automatic logic [1:0] route_out(input logic [4:0] code,
			input rps_pkg::rps_periph_out_t p);
		case (code)
			rps_pkg::SEL_CMP1: route_out = {1'b1, p.comparator1_output};
			rps_pkg::SEL_CMP2: route_out = {1'b1, p.comparator2_output};
			rps_pkg::SEL_UART1_TRANSMIT: route_out = {1'b1, p.uart1_transmit};
			rps_pkg::SEL_UART1_REQUEST_TO_SEND: route_out = {1'b1, p.uart1_request_to_send};
			rps_pkg::SEL_UART2_TRANSMIT: route_out = {1'b1, p.uart2_transmit};
			rps_pkg::SEL_UART2_REQUEST_TO_SEND: route_out = {1'b1, p.uart2_request_to_send};
			rps_pkg::SEL_SPI1_DO: route_out = {1'b1, p.spi1_data_out};
			rps_pkg::SEL_SPI1_CK: route_out = {1'b1, p.spi1_clock_out};
			rps_pkg::SEL_SPI1_SS: route_out = {1'b1, p.spi1_select_out};
			rps_pkg::SEL_SPI2_DO: route_out = {1'b1, p.spi2_data_out};
			rps_pkg::SEL_SPI2_CK: route_out = {1'b1, p.spi2_clock_out};
			rps_pkg::SEL_SPI2_SS: route_out = {1'b1, p.spi2_select_out};
			rps_pkg::SEL_CAN_TX: route_out = {1'b1, p.can_transmit};
			rps_pkg::SEL_CMP_OUT1: route_out = {1'b1, p.compare1_output};
			rps_pkg::SEL_CMP_OUT2: route_out = {1'b1, p.compare2_output};
			rps_pkg::SEL_CMP_OUT3: route_out = {1'b1, p.compare3_output};
			rps_pkg::SEL_CMP_OUT4: route_out = {1'b1, p.compare4_output};
			rps_pkg::SEL_QUAD1: route_out = {1'b1, p.quad1_direction};
			rps_pkg::SEL_QUAD2: route_out = {1'b1, p.quad2_direction};
			default: route_out = 2'h0;
		endcase
	endfunction

	// Input code to pin level; ground and out-of-range codes give zero
	function automatic logic pick_pin(input logic [4:0] sel,
			input logic [NUM_PINS-1:0] pins);
		if (sel <= rps_pkg::SEL_PIN_MAX && int'(sel) < NUM_PINS) begin
			pick_pin = pins[sel];
		end else begin
			pick_pin = 1'b0;
		end
	endfunction

	// Byte address of input slot i
	function automatic logic in_hit(input logic [7:0] a, input int i);
		in_hit = (a == rps_pkg::IN_BASE_OFS + {2'h0, rps_pkg::IN_INDEX[i], 2'h0});
	endfunction

	// Byte address of output slot k
	function automatic logic out_hit(input logic [7:0] a, input int k);
		out_hit = (a == rps_pkg::OUT_BASE_OFS + 8'(k * 4));
	endfunction

	// Bus data phase and lock state
	rps_pkg::rps_addr_phase_t dp;
	logic dp_valid;
	logic wr_en;
	logic osc_wr;
	logic lock;
	logic lock_once;
	logic cfg_q;
	logic cfg_taken;
	logic lock_change_ok;
	logic lock_seen;
	rps_pkg::rps_key_state_t key_state;
	rps_pkg::rps_key_state_t next_key_state;
	// Selector storage; only five input registers exist in this block
	logic [15:0] in_reg [rps_pkg::IN_REGS];
	logic [15:0] out_reg [OUT_REGS];
	logic [15:0] in_shadow [rps_pkg::IN_REGS];
	logic [15:0] out_shadow [OUT_REGS];
	logic [31:0] rd_word;
	logic differ;
	logic [4:0] pin_code [NUM_PINS];
	logic [1:0] pin_route [NUM_PINS];

	// Address phase capture; the slave has one selector region, low byte decodes
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dp_valid <= 1'b0;
			dp <= '0;
		end else if (hready) begin
			dp_valid <= hsel && htrans[1];
			dp <= '{addr: haddr[7:0], write: hwrite, size: hsize};
		end
	end

	// One wait state on reads so read data always follows prior writes
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hreadyout <= 1'b1;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			hreadyout <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
		end
	end

	// Every transfer, mapped or not, answers OKAY
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hresp <= rps_pkg::HRESP_OKAY;
		end else begin
			hresp <= rps_pkg::HRESP_OKAY;
		end
	end

	// Only whole-word writes take effect
	assign wr_en = dp_valid && dp.write && dp.size == rps_pkg::HSIZE_WORD;
	assign osc_wr = wr_en && dp.addr == rps_pkg::OSC_CTRL_OFS;

	// Configuration option caught once after reset release
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfg_q <= rps_pkg::SINGLE_SESSION_DEFAULT;
			cfg_taken <= 1'b0;
		end else if (!cfg_taken) begin
			cfg_q <= single_session_lock_cfg;
			cfg_taken <= 1'b1;
		end
	end

	// Key sequence tracker on low byte of the control register
	always_comb begin
		next_key_state = key_state;
		case (key_state)
			rps_pkg::KEY_IDLE: begin
				if (osc_wr && hwdata[7:0] == rps_pkg::KEY_FIRST) begin
					next_key_state = rps_pkg::KEY_HALF;
				end
			end
			rps_pkg::KEY_HALF: begin
				if (osc_wr) begin
					if (hwdata[7:0] == rps_pkg::KEY_SECOND) begin
						next_key_state = rps_pkg::KEY_OPEN;
					end else if (hwdata[7:0] == rps_pkg::KEY_FIRST) begin
						next_key_state = rps_pkg::KEY_HALF;
					end else begin
						next_key_state = rps_pkg::KEY_IDLE;
					end
				end
			end
			rps_pkg::KEY_OPEN: begin
				if (osc_wr) begin
					next_key_state = rps_pkg::KEY_IDLE; // One change per sequence
				end
			end
			default: next_key_state = rps_pkg::KEY_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			key_state <= rps_pkg::KEY_IDLE;
		end else begin
			key_state <= next_key_state;
		end
	end

	// Clearing refused once set while single-session mode is active;
	// the live lock bit counts too, so no gap opens before the sticky flag follows
	assign lock_seen = lock || lock_once;
	assign lock_change_ok = hwdata[rps_pkg::LOCK_BIT] || !(cfg_q && lock_seen);

	// Write lock; no automatic re-arm, changes only after the keys
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lock <= rps_pkg::LOCK_RESET;
		end else if (osc_wr && key_state == rps_pkg::KEY_OPEN && lock_change_ok) begin
			lock <= hwdata[rps_pkg::LOCK_BIT];
		end
	end

	// Remembers that the lock has been set in this reset period
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lock_once <= 1'b0;
		end else if (lock) begin
			lock_once <= 1'b1;
		end
	end

	// Input selector registers; unimplemented bits never store
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < rps_pkg::IN_REGS; i++) begin
				in_reg[i] <= rps_pkg::IN_RESET & rps_pkg::IN_MASK[i];
			end
		end else if (wr_en && !lock) begin
			for (int i = 0; i < rps_pkg::IN_REGS; i++) begin
				if (in_hit(dp.addr, i)) begin
					in_reg[i] <= hwdata[15:0] & rps_pkg::IN_MASK[i];
				end
			end
		end
	end

	// Output selector registers, two pins per register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int k = 0; k < OUT_REGS; k++) begin
				out_reg[k] <= rps_pkg::OUT_RESET;
			end
		end else if (wr_en && !lock) begin
			for (int k = 0; k < OUT_REGS; k++) begin
				if (out_hit(dp.addr, k)) begin
					out_reg[k] <= hwdata[15:0] & rps_pkg::OUT_MASK;
				end
			end
		end
	end

	// Shadow copies follow only legitimate writes; a disturbed cell shows as a difference
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < rps_pkg::IN_REGS; i++) begin
				in_shadow[i] <= rps_pkg::IN_RESET & rps_pkg::IN_MASK[i];
			end
			for (int k = 0; k < OUT_REGS; k++) begin
				out_shadow[k] <= rps_pkg::OUT_RESET;
			end
		end else if (wr_en && !lock) begin
			for (int i = 0; i < rps_pkg::IN_REGS; i++) begin
				if (in_hit(dp.addr, i)) begin
					in_shadow[i] <= hwdata[15:0] & rps_pkg::IN_MASK[i];
				end
			end
			for (int k = 0; k < OUT_REGS; k++) begin
				if (out_hit(dp.addr, k)) begin
					out_shadow[k] <= hwdata[15:0] & rps_pkg::OUT_MASK;
				end
			end
		end
	end

	// Continuous compare of every selector against its shadow
	always_comb begin
		differ = 1'b0;
		for (int i = 0; i < rps_pkg::IN_REGS; i++) begin
			differ = differ | (in_reg[i] != in_shadow[i]);
		end
		for (int k = 0; k < OUT_REGS; k++) begin
			differ = differ | (out_reg[k] != out_shadow[k]);
		end
	end

	// Sticky until the reset it requests clears it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			map_mismatch_reset <= 1'b0;
		end else if (differ) begin
			map_mismatch_reset <= 1'b1;
		end
	end

	// Read decode; unmapped offsets read zero
	always_comb begin
		rd_word = 32'h0000_0000;
		if (dp.addr == rps_pkg::OSC_CTRL_OFS) begin
			rd_word[rps_pkg::LOCK_BIT] = lock;
		end else if (dp.addr == rps_pkg::STATUS_OFS) begin
			// Status, bit 4 down: mismatch, option, once set, key armed, lock
			rd_word[4:0] = {map_mismatch_reset, cfg_q, lock_once,
				key_state == rps_pkg::KEY_OPEN, lock};
		end
		for (int i = 0; i < rps_pkg::IN_REGS; i++) begin
			if (in_hit(dp.addr, i)) begin
				rd_word[15:0] = in_reg[i];
			end
		end
		for (int k = 0; k < OUT_REGS; k++) begin
			if (out_hit(dp.addr, k)) begin
				rd_word[15:0] = out_reg[k];
			end
		end
	end

	// Read data loaded in the wait cycle, valid when hreadyout returns high
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
		end else if (dp_valid && !dp.write && !hreadyout) begin
			hrdata <= rd_word;
		end
	end

	// Per-pin field and routing decision, kept out of the pin flops
	always_comb begin
		for (int p = 0; p < NUM_PINS; p++) begin
			pin_code[p] = out_reg[p / 2][(p % 2) * rps_pkg::HI_FIELD +: 5];
			pin_route[p] = route_out(pin_code[p], periph_out);
		end
	end

	// Pin side: chosen peripheral drives the pin, otherwise the port keeps it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pin_out <= '0;
			pin_oe <= '0;
		end else begin
			for (int p = 0; p < NUM_PINS; p++) begin
				if (pin_route[p][1]) begin
					pin_out[p] <= pin_route[p][0];
					pin_oe[p] <= 1'b1;
				end else begin
					pin_out[p] <= port_out[p];
					pin_oe[p] <= port_oe[p];
				end
			end
		end
	end

	// Peripheral inputs; direction stays with the port, so pins must be inputs
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			periph_in <= '0;
		end else begin
			periph_in.ext_irq1 <= pick_pin(in_reg[0][rps_pkg::HI_FIELD +: 5], pin_in);
			periph_in.ext_irq2 <= pick_pin(in_reg[1][rps_pkg::LO_FIELD +: 5], pin_in);
			periph_in.tmr2_clk <= pick_pin(in_reg[2][rps_pkg::LO_FIELD +: 5], pin_in);
			periph_in.tmr3_clk <= pick_pin(in_reg[2][rps_pkg::HI_FIELD +: 5], pin_in);
			periph_in.tmr4_clk <= pick_pin(in_reg[3][rps_pkg::LO_FIELD +: 5], pin_in);
			periph_in.tmr5_clk <= pick_pin(in_reg[3][rps_pkg::HI_FIELD +: 5], pin_in);
			periph_in.capture1 <= pick_pin(in_reg[4][rps_pkg::LO_FIELD +: 5], pin_in);
			periph_in.capture2 <= pick_pin(in_reg[4][rps_pkg::HI_FIELD +: 5], pin_in);
		end
	end

endmodule // rps_pin_select
`default_nettype wire

// *** tb/rps_sva.sv ***
// Assertion checker for the remappable pin select block
`default_nettype none
module rps_sva #(
	parameter int NUM_PINS = 26
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [1:0] hresp,
	input wire logic [31:0] hrdata,
	input wire logic [NUM_PINS-1:0] port_out,
	input wire logic [NUM_PINS-1:0] port_oe,
	input wire logic [NUM_PINS-1:0] pin_out,
	input wire logic [NUM_PINS-1:0] pin_oe,
	input wire rps_pkg::rps_periph_in_t periph_in,
	input wire logic map_mismatch_reset
);
	default clocking dcb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Requests accepted by the slave
	logic rd_take;
	logic wr_take;
	assign rd_take = hsel && hready && htrans[1] && !hwrite;
	assign wr_take = hsel && hready && htrans[1] && hwrite;

	a_resp_okay: assert property (hresp == rps_pkg::HRESP_OKAY)
		else $error("bus response not okay");
	a_write_nowait: assert property (wr_take |=> hreadyout)
		else $error("write stalled the bus");
	a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_wait_cause: assert property (!hreadyout |-> $past(rd_take))
		else $error("wait state without a read");
	a_data_stand: assert property ($changed(hrdata) |-> $rose(hreadyout))
		else $error("read data moved outside a read");
	a_upper_zero: assert property (hrdata[31:13] == 19'h0)
		else $error("unimplemented bits read nonzero");
	a_no_mismatch: assert property (!map_mismatch_reset)
		else $error("mismatch reset without a fault");
	// Cleared map after reset leaves every pad on port control
	a_pins_default: assert property ($fell(rst) |=>
		pin_out == $past(port_out) && pin_oe == $past(port_oe))
		else $error("pins not on port control after reset");
	a_ground_default: assert property ($fell(rst) |=> periph_in == 8'h0)
		else $error("peripheral inputs not grounded after reset");

	c_read: cover property (rd_take);
	c_write: cover property (wr_take);
	c_pin_drive: cover property (|pin_oe);
endmodule // rps_sva
bind rps_pin_select rps_sva #(.NUM_PINS(NUM_PINS)) u_sva (
	.clk_sys(clk_sys),
	.rst(rst),
	.hsel(hsel),
	.htrans(htrans),
	.hwrite(hwrite),
	.hready(hready),
	.hreadyout(hreadyout),
	.hresp(hresp),
	.hrdata(hrdata),
	.port_out(port_out),
	.port_oe(port_oe),
	.pin_out(pin_out),
	.pin_oe(pin_oe),
	.periph_in(periph_in),
	.map_mismatch_reset(map_mismatch_reset)
);
`default_nettype wire

// *** tb/rps_far_model.sv ***
// Far-side model of the remappable pads: resolves each pad level
`default_nettype none
module rps_far_model #(
	parameter int NUM_PINS = 26
) (
	input wire logic [NUM_PINS-1:0] pin_out,
	input wire logic [NUM_PINS-1:0] pin_oe,
	input wire logic [NUM_PINS-1:0] ext_level,
	output logic [NUM_PINS-1:0] pin_in
);
	// Input routing cannot override a driving pad, so it reads its own drive
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // rps_far_model
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking testbench of the remappable pin select block
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic [1:0] hresp;
	logic [31:0] hrdata;
	logic cfg = 1'b1;
	rps_pkg::rps_periph_out_t periph_out = '0;
	logic [25:0] port_out = 26'h0;
	logic [25:0] port_oe = 26'h0;
	logic [25:0] ext = 26'h0;
	logic [25:0] pin_in, pin_out, pin_oe;
	rps_pkg::rps_periph_in_t periph_in;
	logic mism;
	logic [31:0] r;
	logic [7:0] a;
	logic [4:0] c;
	logic [2:0] wsize = 3'h2;
	int bad_count = 0;
	int comparisons = 0;
	int cycles = 0;

	always #2 clk_sys = ~clk_sys;

	rps_pin_select dut (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.single_session_lock_cfg(cfg), .periph_out(periph_out), .port_out(port_out),
		.port_oe(port_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.periph_in(periph_in), .map_mismatch_reset(mism));
	rps_far_model far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
		end
	endtask

	// One single transfer of size wsize; waits hold every signal until hready
	task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= {24'h0, ad};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= wsize;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		xfer(1'b1, ad, d);
	endtask

	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		xfer(1'b0, ad, 32'h0);
		check(r, e);
	endtask

	task automatic key;
		wr(8'h00, 32'h46);
		wr(8'h00, 32'h57);
	endtask

	// Register update plus one registered routing stage
	task automatic settle;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask

	// Hang guard, far above the roughly six hundred cycles the tests need
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			summarize();
		end
	end

	initial begin
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		// Reset values and implemented bits of input selectors
		for (int i = 0; i < 5; i++) begin
			a = rps_pkg::IN_BASE_OFS + 8'(4 * rps_pkg::IN_INDEX[i]);
			rd(a, {16'h0, rps_pkg::IN_MASK[i]});
			wr(a, 32'hFFFF);
			rd(a, {16'h0, rps_pkg::IN_MASK[i]});
		end
		for (int k = 0; k < 13; k++) begin
			rd(8'h80 + 8'(4 * k), 32'h0);
			wr(8'h80 + 8'(4 * k), 32'hFFFF);
			rd(8'h80 + 8'(4 * k), 32'h1F1F);
		end
		wr(8'hB4, 32'h1F1F);
		rd(8'hB4, 32'h0);
		// A byte-sized write must leave the selector alone
		wsize = 3'h0;
		wr(8'h80, 32'h0);
		wsize = 3'h2;
		rd(8'h80, 32'h1F1F);
		$display("test registers done");
		// Every assigned output code, seen high then low on pad 0
		for (int i = 0; i < 19; i++) begin
			c = (i < 12) ? 5'(i + 1) : (i == 12) ? 5'h10 : (i < 17) ? 5'(i + 5) : 5'(i + 9);
			@(posedge clk_sys);
			periph_out <= 19'h1 << (18 - i);
			wr(8'h80, {27'h0, c});
			settle;
			check({31'h0, pin_out[0]}, 32'h1);
			@(posedge clk_sys);
			periph_out <= ~(19'h1 << (18 - i));
			settle;
			check({31'h0, pin_out[0]}, 32'h0);
		end
		// Null and unassigned codes on pad 1 fall back to port control
		@(posedge clk_sys);
		periph_out <= '0;
		port_out <= 26'h2;
		port_oe <= 26'h2;
		for (int j = 0; j < 3; j++) begin
			c = (j == 0) ? 5'h00 : (j == 1) ? 5'h0D : 5'h1F;
			wr(8'h80, {19'h0, c, 8'h0});
			settle;
			check({30'h0, pin_oe[1], pin_out[1]}, 32'h3);
		end
		@(posedge clk_sys);
		port_out <= 26'h0;
		port_oe <= 26'h0;
		wr(8'h80, 32'h0);
		$display("test output routing done");
		// Field placement: high fields on pad 5, low fields on pad 6
		@(posedge clk_sys);
		ext <= 26'h20;
		for (int i = 0; i < 5; i++) begin
			wr(rps_pkg::IN_BASE_OFS + 8'(4 * rps_pkg::IN_INDEX[i]), 32'h0506);
		end
		settle;
		check({24'h0, periph_in}, 32'h95);
		// Capture 2 over pad numbers and the first code past the pads
		for (int j = 0; j < 4; j++) begin
			c = (j == 0) ? 5'h00 : (j == 1) ? 5'h0D : (j == 2) ? 5'h19 : 5'h1A;
			@(posedge clk_sys);
			// Past the last pad every level is high, so a stray pick would show
			ext <= (j == 3) ? 26'h3FFFFFF : 26'h1 << c;
			wr(8'h5C, {19'h0, c, 8'h1F});
			settle;
			check({30'h0, periph_in.capture2, periph_in.capture1}, (j == 3) ? 32'h0 : 32'h2);
		end
		$display("test input routing done");
		// Lock needs the key; single-session refuses to reopen
		wr(8'h00, 32'h40);
		rd(8'h00, 32'h0);
		key;
		wr(8'h00, 32'h40);
		rd(8'h00, 32'h40);
		wr(8'h80, 32'h0303);
		rd(8'h80, 32'h0);
		key;
		wr(8'h00, 32'h0);
		rd(8'h00, 32'h40);
		rd(8'h80, 32'h0);
		rd(8'h04, 32'h0D);
		// Second reset with the option programmed off
		@(posedge clk_sys);
		rst <= 1'b1;
		cfg <= 1'b0;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		// A wrong second key byte drops the sequence
		wr(8'h00, 32'h46);
		wr(8'h00, 32'h12);
		wr(8'h00, 32'h57);
		wr(8'h00, 32'h40);
		rd(8'h00, 32'h0);
		key;
		rd(8'h04, 32'h02);
		wr(8'h00, 32'h40);
		key;
		wr(8'h00, 32'h0);
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h04);
		wr(8'h84, 32'h0303);
		wr(8'h88, 32'h1212);
		rd(8'h84, 32'h0303);
		rd(8'h88, 32'h1212);
		check({31'h0, mism}, 32'h0);
		$display("test lock done");
		summarize();
	end
endmodule // testbench
`default_nettype wire
